// file: verilog/video_dram_cycle_sequencer.sv
// video dram cycle sequencer: row, column, output and write enable strobes
`timescale 1ns/1ns
module video_dram_cycle_sequencer
   import vdram_seq_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_start,             // request a cycle, taken when o_ready
   input wire logic [1:0] i_kind,        // access_kind_t of the request
   input wire logic i_display,           // display fetch rather than host read
   input wire logic [3:0] i_burst_len,   // page burst column count, 0 means 1
   output logic o_ready,                 // idle, request may be taken
   output logic o_column_done,           // pulse at each column's end, lower pair
   output logic o_display_done,          // pulse at end of a display cycle
   output logic o_row_strobe_lower_pair,
   output logic o_row_strobe_upper_pair,
   output logic o_column_strobe_lower_pair,
   output logic o_column_strobe_upper_pair,
   output logic o_output_enable_lower_pair,
   output logic o_output_enable_upper_pair,
   output logic o_write_enable_byte_zero,
   output logic o_write_enable_byte_one,
   output logic o_write_enable_byte_two,
   output logic o_write_enable_byte_three
);
   typedef enum logic [1:0] {
      st_idle,
      st_access,
      st_recover
   } seq_state_t;
   typedef struct packed {
      seq_state_t fsm;
      access_kind_t kind;
      logic display;
      logic [3:0] phase;      // lower periods since row fall, column restart or row rise
      logic [3:0] col_start;  // phase of current column fall
      logic [3:0] cols_left;  // columns still to run
      logic first;                  // current column is the first of a burst
      logic [3:0] up_act;           // lower activity, four period delay line
      logic [3:0][3:0] up_phase;    // lower phase, delayed for the upper pair
      logic [3:0][3:0] up_col;      // lower column start, delayed
      logic [3:0] up_wr;            // write flag, delayed
      logic [3:0] up_rd;            // read flag, delayed
      logic col_done;
      logic disp_done;
   } seq_t;
   seq_t s; // sequencer state
   seq_t next_s; // next sequencer state
   logic is_write; // current cycle writes
   logic is_read; // current cycle reads
   logic lower_row_n; // lower pair row strobe
   logic lower_active; // lower pair row held low
   logic upper_row_rise; // upper row strobe from posedge
   logic upper_row_half; // half-period delayed upper row strobe

   assign is_write = (s.kind == kind_write);
   assign is_read = (s.kind != kind_write);
   assign lower_active = (s.fsm == st_access);

   // cycle sequence; every step is one memory clock period
   always_comb begin
      next_s = s;
      next_s.col_done = 1'b0;
      next_s.disp_done = 1'b0;
      unique case (s.fsm)
         st_idle: begin
            if (i_start) begin
               next_s.fsm = st_access;
               next_s.kind = access_kind_t'(i_kind);
               next_s.display = i_display;
               next_s.phase = 4'h0;
               next_s.col_start = T_RAS_TO_CAS;
               next_s.first = 1'b1;
               next_s.cols_left = (i_kind == kind_page_read && i_burst_len != 4'h0) ? i_burst_len : 4'h1;
            end
         end
         st_access: begin
            next_s.phase = step(s.phase);
            // column finished: next column or release the row
            if (s.phase == s.col_start + T_CAS_LOW - 4'h1) begin
               next_s.col_done = 1'b1;
               if (s.cols_left > 4'h1) begin
                  next_s.cols_left = s.cols_left - 4'h1;
                  // phase restarts per column so long bursts never saturate it
                  next_s.phase = 4'h0;
                  next_s.first = 1'b0;
                  // first access carries extra periods before the second column
                  next_s.col_start = s.first ?
                     T_PAGE_CYCLE - T_CAS_LOW + T_FIRST_EXTRA : T_PAGE_CYCLE - T_CAS_LOW;
               end else begin
                  next_s.fsm = st_recover;
                  next_s.phase = 4'h0; // recovery count from row rise
                  next_s.disp_done = s.display;
               end
            end
         end
         st_recover: begin
            // precharge until the random cycle has run its nine periods
            next_s.phase = step(s.phase);
            // row high four periods in all, the take edge being the last
            if (s.phase == T_RANDOM_CYCLE - T_RAS_LOW - 4'h2) begin
               next_s.fsm = st_idle;
            end
         end
         default: next_s.fsm = st_idle;
      endcase
      // upper pair replays the lower inputs four periods later, half below
      // delay line depth is the T_UPPER_LAG count of four
      next_s.up_act = {s.up_act[2:0], lower_active};
      next_s.up_phase = {s.up_phase[2:0], s.phase};
      next_s.up_col = {s.up_col[2:0], s.col_start};
      next_s.up_wr = {s.up_wr[2:0], is_write};
      next_s.up_rd = {s.up_rd[2:0], is_read};
   end

   // register the sequencer state
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         s <= '{fsm: st_idle, kind: kind_write, default: '0};
      end else begin
         s <= next_s;
      end
   end

   // lower pair strobes
   pair_strobe_gen u_lower (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_active(lower_active),
      .i_phase(s.phase),
      .i_col_start(s.col_start),
      .i_is_write(is_write),
      .i_is_read(is_read),
      .i_we_len(T_WE_LOWER),
      .o_row_strobe_n(lower_row_n),
      .o_col_strobe_n(o_column_strobe_lower_pair),
      .o_out_enable_n(o_output_enable_lower_pair),
      .o_write_enable_n(o_write_enable_byte_zero)
   );

   // upper pair strobes, timed from its own row fall
   pair_strobe_gen u_upper (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_active(s.up_act[3]),
      .i_phase(s.up_phase[3]),
      .i_col_start(s.up_col[3]),
      .i_is_write(s.up_wr[3]),
      .i_is_read(s.up_rd[3]),
      .i_we_len(T_WE_UPPER),
      .o_row_strobe_n(upper_row_rise),
      .o_col_strobe_n(o_column_strobe_upper_pair),
      .o_out_enable_n(o_output_enable_upper_pair),
      .o_write_enable_n(o_write_enable_byte_two)
   );

   // falling edge stage gives the extra half period on the upper row strobe
   always_ff @(negedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         upper_row_half <= 1'b1;
      end else begin
         upper_row_half <= upper_row_rise;
      end
   end

   assign o_row_strobe_lower_pair = lower_row_n;
   assign o_row_strobe_upper_pair = upper_row_half;
   assign o_write_enable_byte_one = o_write_enable_byte_zero;
   assign o_write_enable_byte_three = o_write_enable_byte_two;
   assign o_ready = (s.fsm == st_idle);
   assign o_column_done = s.col_done;
   assign o_display_done = s.disp_done;
endmodule

// file: verilog/vdram_seq_pkg.sv
// package of timing counts and types for the video dram cycle sequencer
package vdram_seq_pkg;
   // memory clock figures; one period is the unit of every interval
   localparam int unsigned MCLK_KHZ = 25000;
   localparam logic [3:0] T_RAS_LOW = 4'h5;      // row strobe low, periods
   localparam logic [3:0] T_RAS_TO_CAS = 4'h2;   // row fall to column fall
   localparam logic [3:0] T_CAS_LOW = 4'h3;      // column strobe low
   localparam logic [3:0] T_RANDOM_CYCLE = 4'h9; // random cycle length
   localparam logic [3:0] T_PAGE_CYCLE = 4'h5;   // column to column in a burst
   localparam logic [3:0] T_FIRST_EXTRA = 4'h2;  // first page access is longer
   localparam logic [3:0] T_UPPER_LAG = 4'h4;    // upper pair lag, whole periods
   localparam logic [3:0] T_OE_LAG = 4'h1;       // output enable after column strobe
   localparam logic [3:0] T_WE_UPPER = 4'h5;     // upper write enable low time
   localparam logic [3:0] T_WE_LOWER = 4'h3;     // lower write enable low time
   localparam logic [3:0] T_LAST_PHASE = 4'hf;   // phase counter top
   // kinds of access
   typedef enum logic [1:0] {
      kind_write,
      kind_read,
      kind_page_read
   } access_kind_t;
   // counter step for the one phase count that both pairs share
   function automatic logic [3:0] step(input logic [3:0] value);
      step = (value == T_LAST_PHASE) ? value : value + 4'h1;
   endfunction
endpackage

// file: verilog/pair_strobe_gen.sv
// strobe generator for one bank pair, driven by a shared phase count
`timescale 1ns/1ns
module pair_strobe_gen
   import vdram_seq_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_active,            // cycle under way
   input wire logic [3:0] i_phase,       // periods since this pair's row fall or column restart
   input wire logic [3:0] i_col_start,   // phase of current column fall
   input wire logic i_is_write,          // write cycle
   input wire logic i_is_read,           // read or page read cycle
   input wire logic [3:0] i_we_len,      // write enable low time
   output logic o_row_strobe_n,          // row strobe, active low
   output logic o_col_strobe_n,          // column strobe, active low
   output logic o_out_enable_n,          // output enable, active low
   output logic o_write_enable_n         // write enable, active low
);
   typedef struct packed {
      logic row_n;
      logic col_n;
      logic oe_n;
      logic we_n;
   } pair_state_t;
   pair_state_t state; // registered strobes
   pair_state_t next_state; // next strobes
   logic [3:0] col_rel; // periods since column fall

   // decode the strobes from the phase
   always_comb begin
      col_rel = i_phase - i_col_start;
      next_state.row_n = 1'b1;
      next_state.col_n = 1'b1;
      // output enable is the column strobe one period late, reads only
      next_state.oe_n = state.col_n || !i_is_read;
      next_state.we_n = 1'b1;
      if (i_active) begin
         next_state.row_n = 1'b0;
         if (i_phase >= i_col_start && col_rel < T_CAS_LOW) begin
            next_state.col_n = 1'b0;
         end
         // write enable ends with the column strobe, starts i_we_len before
         if (i_is_write && i_phase >= i_col_start + T_CAS_LOW - i_we_len && i_phase < i_col_start + T_CAS_LOW) begin
            next_state.we_n = 1'b0;
         end
      end
   end

   // register the strobes
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= '{row_n: 1'b1, col_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end else begin
         state <= next_state;
      end
   end

   assign o_row_strobe_n = state.row_n;
   assign o_col_strobe_n = state.col_n;
   assign o_out_enable_n = state.oe_n;
   assign o_write_enable_n = state.we_n;
endmodule

// file: tb/vdram_seq_properties.sv
// checker of strobe sequencing at the sequencer ports
`timescale 1ns/1ns
module vdram_seq_properties (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic [1:0] i_kind,
   input wire logic o_ready,
   input wire logic o_row_strobe_lower_pair,
   input wire logic o_row_strobe_upper_pair,
   input wire logic o_column_strobe_lower_pair,
   input wire logic o_output_enable_lower_pair,
   input wire logic o_write_enable_byte_zero
);
   logic rl, ru, cl, oe, we; // short views of the strobes
   logic [1:0] mode; // bit0 write, bit1 page read, of the last take
   assign rl = o_row_strobe_lower_pair;
   assign ru = o_row_strobe_upper_pair;
   assign cl = o_column_strobe_lower_pair;
   assign oe = o_output_enable_lower_pair;
   assign we = o_write_enable_byte_zero;
   // remember the kind of each taken request
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         mode <= 2'h0;
      end else if (i_start && o_ready) begin
         mode <= {i_kind == 2'h2, i_kind == 2'h0};
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   a_row_low_five: assert property ($fell(rl) && !mode[1] |-> (!rl) [*5] ##1 rl)
      else $error("row low time wrong");
   a_row_to_col: assert property ($fell(rl) |-> ##2 $fell(cl))
      else $error("column fall not two after row");
   a_col_low_three: assert property ($fell(cl) |-> (!cl) [*3] ##1 cl)
      else $error("column low time wrong");
   a_col_spacing: assert property ($fell(cl) |-> ##1 (!$fell(cl)) [*4])
      else $error("column accesses too close");
   a_oe_after_col: assert property ($fell(cl) && !mode[0] |-> ##1 $fell(oe))
      else $error("output enable not one after column");
   a_oe_release: assert property ($rose(cl) && !mode[0] |-> ##1 $rose(oe))
      else $error("output enable release late");
   a_upper_lag: assert property ($fell(rl) |-> ##3 ru ##1 !ru)
      else $error("upper row lag wrong");
   a_we_lower: assert property ($fell(cl) && mode[0] |-> (!we) [*3] ##1 we)
      else $error("lower write enable length wrong");
   a_ready_gap: assert property (i_start && o_ready |=> (!o_ready) [*8])
      else $error("cycles closer than nine periods");
endmodule
bind video_dram_cycle_sequencer vdram_seq_properties u_props (.*);

// file: tb/dram_pair_model.sv
// model of the lower bank pair: counts each column access
`timescale 1ns/1ns
module dram_pair_model (
   input wire logic i_clock,
   input wire logic i_clear,
   input wire logic i_row_strobe_n,
   input wire logic i_col_strobe_n,
   output logic [7:0] o_accesses
);
   logic col_was; // column strobe one period ago
   // a column fall under an open row is one access
   always_ff @(posedge i_clock) begin
      col_was <= i_col_strobe_n;
      if (i_clear) begin
         o_accesses <= 8'h0;
      end else if (col_was && !i_col_strobe_n && !i_row_strobe_n) begin
         o_accesses <= o_accesses + 8'h1;
      end
   end
endmodule

// file: tb/tb_top.sv
// testbench: requests cycles and measures strobe shapes
`timescale 1ns/1ns
module tb_top;
   logic i_clock, i_resetn, i_start, i_display, clear;
   logic [1:0] i_kind;
   logic [3:0] i_burst_len;
   logic o_ready, o_column_done, o_display_done, o_row_strobe_lower_pair, o_row_strobe_upper_pair;
   logic o_column_strobe_lower_pair, o_column_strobe_upper_pair, o_output_enable_lower_pair;
   logic o_output_enable_upper_pair, o_write_enable_byte_zero, o_write_enable_byte_one;
   logic o_write_enable_byte_two, o_write_enable_byte_three;
   logic [7:0] acc; // accesses seen by the memory model
   int error_cnt, n_checks, last;
   int m [8]; // falls, oe low, we0 low, we2 low, col done, disp done, gap1, gap2
   video_dram_cycle_sequencer u_dut (.*);
   dram_pair_model u_mem (.i_clock(i_clock), .i_clear(clear), .i_row_strobe_n(o_row_strobe_lower_pair),
      .i_col_strobe_n(o_column_strobe_lower_pair), .o_accesses(acc));
   // memory clock
   initial begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // compare a counted figure
   task automatic chk(input string what, input int exp, input int got);
      n_checks++;
      if (exp != got) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   // compare a four-state value
   task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (exp !== got) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one request, measured until ready plus a tail for the upper pair
   task automatic run(input logic [1:0] kind, input logic disp, input logic [3:0] burst);
      int left;
      logic prev;
      m = '{default: 0};
      left = 200;
      prev = 1'b1;
      @(posedge i_clock);
      i_kind <= kind;
      i_display <= disp;
      i_burst_len <= burst;
      i_start <= 1'b1;
      clear <= 1'b1;
      @(posedge i_clock);
      i_start <= 1'b0;
      clear <= 1'b0;
      for (int n = 0; left > 0; n++) begin
         @(posedge i_clock);
         #10;
         if (prev && !o_column_strobe_lower_pair) begin
            if (m[0] == 1) m[6] = n - last;
            if (m[0] == 2) m[7] = n - last;
            last = n;
            m[0]++;
         end
         prev = o_column_strobe_lower_pair;
         m[1] += (o_output_enable_lower_pair === 1'b0);
         m[2] += (o_write_enable_byte_zero === 1'b0 && o_write_enable_byte_one === 1'b0);
         m[3] += (o_write_enable_byte_two === 1'b0 && o_write_enable_byte_three === 1'b0);
         m[4] += (o_column_done === 1'b1);
         m[5] += (o_display_done === 1'b1);
         if (o_ready === 1'b1 && left > 8) left = 8;
         left--;
         if (n > 99) begin
            chk("ready return", 1, 0);
            wrap_up();
         end
      end
   endtask
   task automatic sc_write();
      run(2'h0, 1'b0, 4'h0);
      chk("write columns", 1, m[0]);
      chk("lower write enable", 3, m[2]);
      chk("upper write enable", 5, m[3]);
      chk("write output enable", 0, m[1]);
      chk_v("write accesses", 8'h01, acc);
   endtask
   task automatic sc_reads();
      for (int d = 0; d < 2; d++) begin
         run(2'h1, d[0], 4'h0);
         chk("read output enable", 3, m[1]);
         chk("display done", d, m[5]);
         chk("column done", 1, m[4]);
      end
      run(2'h3, 1'b0, 4'h0);
      chk("odd kind output enable", 3, m[1]);
   endtask
   task automatic sc_page();
      run(2'h2, 1'b1, 4'h4);
      chk("page columns", 4, m[0]);
      chk_v("page accesses", 8'h04, acc);
      chk("page output enable", 12, m[1]);
      chk("first gap", 7, m[6]);
      chk("later gap", 5, m[7]);
      chk("page column done", 4, m[4]);
      run(2'h2, 1'b0, 4'h0);
      chk("zero burst columns", 1, m[0]);
   endtask
   task automatic sc_reset();
      run(2'h0, 1'b0, 4'h0);
      @(posedge i_clock);
      i_start <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_start <= 1'b0;
      i_resetn <= 1'b0;
      @(negedge i_clock);
      chk_v("row after reset", 8'h01, {7'h0, o_row_strobe_lower_pair});
      chk_v("ready after reset", 8'h01, {7'h0, o_ready});
      @(posedge i_clock);
      i_resetn <= 1'b1;
   endtask
   // main sequence
   initial begin
      {i_resetn, i_start, i_display, clear, i_kind, i_burst_len} = '0;
      repeat (16) @(posedge i_clock);
      i_resetn <= 1'b1;
      sc_write();
      sc_reads();
      sc_page();
      sc_reset();
      sc_write();
      wrap_up();
   end
endmodule
